// ===== rtl/udc_counter.sv
// four-bit synchronous up/down counter, decade or binary variant
//
// Behaviour
// [RULE1] priority: async clear, sync clear, load, count, hold
// [RULE2] async clear low forces state zero immediately
// [RULE3] sync clear low zeroes state next edge
// [RULE4] load low captures preset_in next edge
// [RULE5] both count enables low needed to count
// [RULE6] dir_up high increments, low decrements
// [RULE7] controls sampled only at rising clock edge
// [RULE8] terminal count low at range end, trickle low
// [RULE9] terminal count decoded combinationally from state
// [RULE10] clocked carry low only during clock low
// [RULE11] output enable low shows state, else released
// [RULE12] state keeps running while outputs released
// [RULE13] never clock storage from terminal count
// [RULE14] cascade through terminal count into enables
// [RULE15] decade variant wraps nine to zero
// [RULE16] binary variant wraps fifteen to zero
// [RULE17] parameter picks variant, wrap and maximum
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_counter #(
   parameter bit DECADE = 1'b1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic async_clear_n,
   input wire logic sync_clear_n,
   input wire logic load_n,
   input wire logic count_en_par_n,
   input wire logic count_en_trickle_n,
   input wire logic dir_up,
   input wire logic output_en_n,
   input wire logic [3:0] preset_in,
   output logic [3:0] count_out,
   output logic count_out_oe,
   output logic terminal_count_n,
   output logic clocked_carry_n
);

   localparam udc_pkg::udc_count_t MAX_VAL = DECADE ? `UDC_MAX_DECADE : `UDC_MAX_BINARY;

   udc_pkg::udc_count_t cnt_q;
   udc_pkg::udc_count_t cnt_d;
   udc_pkg::udc_mode_t mode;
   logic count_en;
   logic carry_ready;

   udc_step_if step_bus ();

   udc_step #(
      .DECADE(DECADE)
   ) u_step (
      .s(step_bus)
   );

   assign step_bus.cnt = cnt_q;

   // mode decode; async clear lives on the flop itself
   assign count_en = !count_en_par_n && !count_en_trickle_n; // [RULE5]

   always_comb begin
      if (!sync_clear_n) begin
         mode = udc_pkg::UDC_MODE_SCLR; // [RULE1] [RULE3]
      end else if (!load_n) begin
         mode = udc_pkg::UDC_MODE_LOAD; // [RULE1] [RULE4]
      end else if (count_en) begin
         mode = udc_pkg::UDC_MODE_COUNT; // [RULE1] [RULE5]
      end else begin
         mode = udc_pkg::UDC_MODE_HOLD; // [RULE1]
      end
   end

   always_comb begin
      case (mode)
         udc_pkg::UDC_MODE_SCLR: begin
            cnt_d = `UDC_ZERO; // [RULE3]
         end
         udc_pkg::UDC_MODE_LOAD: begin
            cnt_d = preset_in; // [RULE4]
         end
         udc_pkg::UDC_MODE_COUNT: begin
            cnt_d = dir_up ? step_bus.next_up : step_bus.next_down; // [RULE6]
         end
         udc_pkg::UDC_MODE_HOLD: begin
            cnt_d = cnt_q;
         end
         default: begin
            cnt_d = cnt_q;
         end
      endcase
   end

   // async clear is kept apart from srst so it acts without any edge;
   // only a constant is loaded under it
   always_ff @(posedge clk or negedge async_clear_n) begin
      if (!async_clear_n) begin
         cnt_q <= `UDC_RESET_VALUE; // [RULE2] [RULE1]
      end else if (srst) begin
         cnt_q <= `UDC_RESET_VALUE;
      end else begin
         cnt_q <= cnt_d; // [RULE7] [RULE12]
      end
   end

   // decoded without a flop, so it may spike while the state settles;
   // downstream storage must not be clocked from it
   assign terminal_count_n = !(!count_en_trickle_n &&
      ((dir_up && step_bus.at_max) || (!dir_up && step_bus.at_zero))); // [RULE8] [RULE9]

   assign carry_ready = sync_clear_n && load_n && count_en && !terminal_count_n;

   // gated by the clock low phase, giving a clean pulse for cascading
   assign clocked_carry_n = !(carry_ready && !clk); // [RULE10]

   // the pad drives only while enabled; the state flops keep running
   assign count_out = cnt_q; // [RULE11]
   assign count_out_oe = !output_en_n; // [RULE11] [RULE12]

   // checks: a following edge is only meaningful while async clear stays high
   sequence s_sclr;
      async_clear_n && !sync_clear_n;
   endsequence

   sequence s_load;
      async_clear_n && sync_clear_n && !load_n;
   endsequence

   sequence s_up;
      async_clear_n && sync_clear_n && load_n && count_en && dir_up;
   endsequence

   sequence s_down;
      async_clear_n && sync_clear_n && load_n && count_en && !dir_up;
   endsequence

   sequence s_hold;
      async_clear_n && sync_clear_n && load_n && !count_en;
   endsequence

   chk_async_clear_zero: assert property ( // [RULE2]
      @(posedge clk) disable iff (srst)
      !async_clear_n |-> (cnt_q == `UDC_ZERO) && (count_out == `UDC_ZERO)
   ) else $error("state not zero while async clear is low");

   chk_sync_clear_wins: assert property ( // [RULE3]
      @(posedge clk) disable iff (srst)
      s_sclr ##1 async_clear_n |-> cnt_q == `UDC_ZERO
   ) else $error("sync clear did not zero the state");

   chk_load_preset: assert property ( // [RULE4]
      @(posedge clk) disable iff (srst)
      s_load ##1 async_clear_n |-> cnt_q == $past(preset_in)
   ) else $error("load did not capture the preset value");

   chk_count_up_wrap: assert property ( // [RULE6]
      @(posedge clk) disable iff (srst)
      s_up ##1 async_clear_n |->
         cnt_q == (($past(cnt_q) == MAX_VAL) ? `UDC_ZERO : $past(cnt_q) + `UDC_ONE)
   ) else $error("up count step or wrap wrong");

   chk_count_down_wrap: assert property ( // [RULE15]
      @(posedge clk) disable iff (srst)
      s_down ##1 async_clear_n |->
         cnt_q == (($past(cnt_q) == `UDC_ZERO) ? MAX_VAL : $past(cnt_q) - `UDC_ONE)
   ) else $error("down count step or wrap wrong");

   chk_hold_stable: assert property ( // [RULE5]
      @(posedge clk) disable iff (srst)
      s_hold ##1 async_clear_n |-> $stable(cnt_q)
   ) else $error("state moved while counting was inhibited");

   chk_tc_decode: assert property ( // [RULE8]
      @(posedge clk) disable iff (srst)
      terminal_count_n == !(!count_en_trickle_n &&
         ((dir_up && cnt_q == MAX_VAL) || (!dir_up && cnt_q == `UDC_ZERO)))
   ) else $error("terminal count decode wrong");

   chk_cc_low_phase: assert property ( // [RULE10]
      @(posedge clk) disable iff (srst)
      clocked_carry_n == !(sync_clear_n && load_n && !count_en_par_n &&
         !count_en_trickle_n && !terminal_count_n)
   ) else $error("clocked carry wrong during clock low phase");

   chk_cc_high_phase: assert property ( // [RULE10]
      @(negedge clk) disable iff (srst)
      clocked_carry_n
   ) else $error("clocked carry low during clock high phase");

   chk_oe_follow: assert property ( // [RULE11]
      @(posedge clk) disable iff (srst)
      (count_out_oe == !output_en_n) && (count_out == cnt_q)
   ) else $error("output enable or data does not follow state");

   // every count step moves the state, wrap included, so a stuck state shows
   chk_released_runs: assert property ( // [RULE12]
      @(posedge clk) disable iff (srst)
      output_en_n && async_clear_n && sync_clear_n && load_n && count_en && dir_up
         ##1 async_clear_n |-> cnt_q != $past(cnt_q)
   ) else $error("state stopped while outputs released");

endmodule : udc_counter

// ===== rtl/udc_cfg.svh
// constants for the four-bit up/down counter
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH

`define UDC_WIDTH 4
`define UDC_RESET_VALUE 4'h0
`define UDC_ZERO 4'h0
`define UDC_ONE 4'h1
`define UDC_MAX_DECADE 4'h9
`define UDC_MAX_BINARY 4'hF

`endif

// ===== rtl/udc_pkg.sv
// types shared by the counter modules
package udc_pkg;

   typedef logic [3:0] udc_count_t;

   // gray order along hold -> count -> load -> clear
   typedef enum logic [1:0] {
      UDC_MODE_HOLD = 2'h0,
      UDC_MODE_COUNT = 2'h1,
      UDC_MODE_LOAD = 2'h3,
      UDC_MODE_SCLR = 2'h2
   } udc_mode_t;

endpackage : udc_pkg

// ===== rtl/udc_step_if.sv
// state in, neighbour states and end-of-range flags out
`timescale 1ns/1ps
interface udc_step_if;
   udc_pkg::udc_count_t cnt;
   udc_pkg::udc_count_t next_up;
   udc_pkg::udc_count_t next_down;
   logic at_max;
   logic at_zero;

   modport calc (
      input cnt,
      output next_up,
      output next_down,
      output at_max,
      output at_zero
   );

   modport user (
      output cnt,
      input next_up,
      input next_down,
      input at_max,
      input at_zero
   );
endinterface : udc_step_if

// ===== rtl/udc_step.sv
// successor, predecessor and range decode for one counter stage
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_step #(
   parameter bit DECADE = 1'b1
) (
   udc_step_if.calc s
);

   localparam udc_pkg::udc_count_t MAX_VAL = DECADE ? `UDC_MAX_DECADE : `UDC_MAX_BINARY;

   assign s.at_max = (s.cnt == MAX_VAL); // [RULE17]
   assign s.at_zero = (s.cnt == `UDC_ZERO);

   // wrap at the variant's maximum; above-range states of the decade
   // variant step through binary, wrapping through zero going up and stepping into range going down
   assign s.next_up = s.at_max ? `UDC_ZERO : s.cnt + `UDC_ONE; // [RULE15] [RULE16]
   assign s.next_down = s.at_zero ? MAX_VAL : s.cnt - `UDC_ONE; // [RULE15] [RULE16]

endmodule : udc_step

// ===== tb/udc_carry_watch.sv
// downstream stages fed from the counter's clocked carry and terminal count
`timescale 1ns/1ps
module udc_carry_watch (
   input wire logic clk,
   input wire logic carry_n,
   input wire logic tc_n,
   output int carries,
   output int stage_ticks
);
   // clocked from the carry, never from terminal count: the decode can spike
   always_ff @(posedge carry_n) begin
      carries <= carries + 1;
   end
   // next cascaded stage: its one count enable comes from terminal count
   always_ff @(posedge clk) begin
      if (!tc_n) begin
         stage_ticks <= stage_ticks + 1;
      end
   end
endmodule : udc_carry_watch

// ===== tb/test_updown_counter_4bit.sv
// self-checking bench for the decade and binary up/down counters
`timescale 1ns/1ps
module test_updown_counter_4bit;
   logic clk, srst, async_clear_n, sync_clear_n, load_n, count_en_par_n;
   logic count_en_trickle_n, dir_up, output_en_n, count_out_oe;
   logic terminal_count_n, clocked_carry_n;
   logic [3:0] preset_in, count_out, count_bin;
   logic tc_bin;
   int n_fail, total_checks, carries, c0, stage_ticks, t0;
   udc_counter #(.DECADE(1'b1)) dut (.clk(clk), .srst(srst), .async_clear_n(async_clear_n),
      .sync_clear_n(sync_clear_n), .load_n(load_n), .count_en_par_n(count_en_par_n),
      .count_en_trickle_n(count_en_trickle_n), .dir_up(dir_up), .output_en_n(output_en_n),
      .preset_in(preset_in), .count_out(count_out), .count_out_oe(count_out_oe),
      .terminal_count_n(terminal_count_n), .clocked_carry_n(clocked_carry_n));
   udc_counter #(.DECADE(1'b0)) dut_bin (.clk(clk), .srst(srst), .async_clear_n(async_clear_n),
      .sync_clear_n(sync_clear_n), .load_n(load_n), .count_en_par_n(count_en_par_n),
      .count_en_trickle_n(count_en_trickle_n), .dir_up(dir_up), .output_en_n(output_en_n),
      .preset_in(preset_in), .count_out(count_bin), .count_out_oe(),
      .terminal_count_n(tc_bin), .clocked_carry_n());
   udc_carry_watch partner (.clk(clk), .carry_n(clocked_carry_n), .tc_n(terminal_count_n),
      .carries(carries), .stage_ticks(stage_ticks));
   task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : chk
   // step waits n rising edges and then 1 ns, where most inputs change
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic ctl(logic sc, logic ld, logic pn, logic tn, logic up, logic [3:0] p);
      sync_clear_n = sc;
      load_n = ld;
      count_en_par_n = pn;
      count_en_trickle_n = tn;
      dir_up = up;
      preset_in = p;
   endtask : ctl
   task automatic t_wrap;
      ctl(1, 0, 0, 0, 1, 4'h7);
      step(1);
      chk("load", 4'h7, count_out);
      ctl(1, 1, 0, 0, 1, 4'h0);
      step(2);
      chk("up", 4'h9, count_out);
      chk("tc at max", 1'b0, terminal_count_n);
      c0 = carries;
      t0 = stage_ticks;
      @(negedge clk);
      #1;
      chk("carry low phase", 1'b0, clocked_carry_n);
      step(1);
      chk("carry high phase", 1'b1, clocked_carry_n);
      chk("carries seen", 4'h1, 4'(carries - c0));
      chk("stage ticks", 4'h1, 4'(stage_ticks - t0));
      chk("wrap up", 4'h0, count_out);
      chk("tc released", 1'b1, terminal_count_n);
      dir_up = 0;
      #1;
      chk("tc at zero down", 1'b0, terminal_count_n);
      step(1);
      chk("wrap down", 4'h9, count_out);
      $display("wrap test done");
   endtask : t_wrap
   task automatic t_binary;
      ctl(1, 0, 0, 0, 1, 4'hF);
      step(1);
      chk("bin load", 4'hF, count_bin);
      ctl(1, 1, 0, 0, 1, 4'h0);
      #1;
      chk("bin tc at max", 1'b0, tc_bin);
      chk("dec tc above range", 1'b1, terminal_count_n);
      step(1);
      chk("bin wrap up", 4'h0, count_bin);
      dir_up = 0;
      step(1);
      chk("bin wrap down", 4'hF, count_bin);
      chk("dec wrap down", 4'h9, count_out);
      $display("binary test done");
   endtask : t_binary
   task automatic t_priority;
      ctl(0, 0, 0, 0, 1, 4'h5);
      step(1);
      chk("sync clear", 4'h0, count_out);
      ctl(1, 0, 0, 0, 1, 4'h5);
      step(1);
      chk("load over count", 4'h5, count_out);
      ctl(1, 1, 1, 0, 1, 4'h0);
      step(2);
      chk("hold par", 4'h5, count_out);
      ctl(1, 0, 0, 0, 0, 4'h0);
      step(1);
      ctl(1, 1, 0, 1, 0, 4'h0);
      step(1);
      chk("hold trickle", 4'h0, count_out);
      chk("tc gated", 1'b1, terminal_count_n);
      count_en_trickle_n = 0;
      count_en_par_n = 1;
      @(negedge clk);
      #1;
      chk("tc trickle low", 1'b0, terminal_count_n);
      chk("carry needs par", 1'b1, clocked_carry_n);
      load_n = 0;
      #1;
      load_n = 1;
      step(1);
      chk("mid-cycle load ignored", 4'h0, count_out);
      $display("priority test done");
   endtask : t_priority
   task automatic t_async;
      ctl(1, 1, 0, 0, 1, 4'h0);
      output_en_n = 1;
      #1;
      chk("oe off", 1'b0, count_out_oe);
      step(3);
      chk("runs while off", 4'h3, count_out);
      output_en_n = 0;
      load_n = 0;
      async_clear_n = 0;
      #1;
      chk("oe on", 1'b1, count_out_oe);
      chk("async clear", 4'h0, count_out);
      step(1);
      chk("async over load", 4'h0, count_out);
      async_clear_n = 1;
      $display("async test done");
   endtask : t_async
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial begin
      #20000;
      n_fail++;
      close_out;
   end
   initial begin
      srst = 1;
      async_clear_n = 1;
      output_en_n = 0;
      ctl(1, 1, 1, 1, 1, 4'h0);
      repeat (20) @(posedge clk);
      #1;
      srst = 0;
      chk("reset value", 4'h0, count_out);
      t_wrap;
      t_binary;
      t_priority;
      t_async;
      close_out;
   end
endmodule : test_updown_counter_4bit
